// file: include/lioh_pkg.sv
/*
 Package for the host-side controller of a latched 8-bit port with a
 service-request flag. Holds widths, timing counts, the pin bundles that
 travel between host and port, and the controller state encoding.
 Assumes a 200 MHz system clock.
*/
package lioh_pkg;

    // Data path width of the port
    localparam int unsigned DATA_W = 8;

    // Clock period in picoseconds (200 MHz)
    localparam int unsigned CLK_PS = 5000;

    // Least pulse width on select and strobe, and data set-up and hold, in ns
    localparam int unsigned PULSE_NS = 30;
    localparam int unsigned SETUP_NS = 15;
    localparam int unsigned HOLD_NS  = 20;
    // Longest enable-to-output delay, waited before sampling read data
    localparam int unsigned ENABLE_NS = 45;

    // Cycle counts, least times rounded up
    localparam int unsigned PULSE_CYC  = (PULSE_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int unsigned SETUP_CYC  = (SETUP_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int unsigned HOLD_CYC   = (HOLD_NS * 1000 + CLK_PS - 1) / CLK_PS;
    localparam int unsigned ENABLE_CYC = (ENABLE_NS * 1000 + CLK_PS - 1) / CLK_PS;

    // Width of the phase counter
    localparam int unsigned CNT_W = 4;

    // Pin levels
    localparam logic PIN_LO = 1'b0;
    localparam logic PIN_HI = 1'b1;
    localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;

    // Pins the host drives into the port
    typedef struct packed {
        logic              select_low_n;
        logic              select_high;
        logic              port_direction_pin;
        logic              latch_strobe;
        logic              port_reset_n;
        logic [DATA_W-1:0] input_lines;
    } lioh_drive_t;

    // Pins the host reads back from the port
    typedef struct packed {
        logic              int_n;
        logic [DATA_W-1:0] output_lines;
    } lioh_sense_t;

    // Controller states, one-hot
    typedef enum logic [5:0] {
        ST_INIT  = 6'h01,
        ST_IDLE  = 6'h02,
        ST_SETUP = 6'h04,
        ST_PULSE = 6'h08,
        ST_HOLD  = 6'h10,
        ST_READ  = 6'h20
    } lioh_state_t;

endpackage

// file: verilog/lioh_sync.sv
/*
 Two-flop synchroniser for a bundle of port pins.
 Assumes the inputs are asynchronous to clock; the first stage is read only
 by the second.
*/
`timescale 1ns/100ps
module lioh_sync #(
    parameter int unsigned WIDTH = 9
) (
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             rst,
    // Asynchronous pins and their synchronised copy
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_r;

    // Two stages; reset value all ones matches idle pins (interrupt high)
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            meta_r   <= '1;
            sync_out <= '1;
        end
        else
        begin
            meta_r   <= async_in;
            sync_out <= meta_r;
        end
    end

endmodule

// file: verilog/lioh_ctrl.sv
/*
 Host-side controller that drives a latched 8-bit port with a service
 request flag through its pins: clears it, writes data in output mode by
 pulsing the select, reads data in input mode by selecting it, and watches
 the active-low interrupt it raises when a peripheral strobes.
 Assumes the port's pins are wired straight to the drive and sense bundles,
 and that the peripheral's strobe reaches the port directly when enabled.
*/
`timescale 1ns/100ps

module lioh_ctrl #(
    parameter int unsigned DATA_W = lioh_pkg::DATA_W
) (
    // Clock and reset
    input  wire logic              clock,
    input  wire logic              rst,
    // Host command port
    input  wire logic              wr_req,
    input  wire logic              rd_req,
    input  wire logic              clr_req,
    input  wire logic [DATA_W-1:0] wr_data,
    output logic                   busy_r,
    output logic                   done_r,
    output logic      [DATA_W-1:0] rd_data_r,
    output logic                   irq_pending_r,
    // Port pins
    output lioh_pkg::lioh_drive_t  drive_r,
    input  wire lioh_pkg::lioh_sense_t sense
);

    lioh_pkg::lioh_state_t state_r;
    lioh_pkg::lioh_state_t state_nxt;
    logic [lioh_pkg::CNT_W-1:0] cnt_r;
    logic [lioh_pkg::CNT_W-1:0] cnt_nxt;
    logic                       op_wr_r;
    logic                       op_clr_r;
    lioh_pkg::lioh_sense_t      sense_s;
    logic                       phase_done;
    logic                       op_wr_nxt;
    logic [1:0]                 sel_seen_r;

    // Pins come from the port's own timing, so synchronise them
    lioh_sync #(
        .WIDTH    ($bits(lioh_pkg::lioh_sense_t))
    ) u_sync (
        .clock    (clock),
        .rst      (rst),
        .async_in (sense),
        .sync_out (sense_s)
    );

    assign phase_done = (cnt_r == '0);

    // Write flag as it stands after this edge, so mode rises with the take
    assign op_wr_nxt = (state_r == lioh_pkg::ST_IDLE) ? (wr_req && !clr_req) : op_wr_r;

    // Sequencer for clear, write and read cycles
    always_comb
    begin
        state_nxt = state_r;
        cnt_nxt   = (cnt_r == '0) ? cnt_r : cnt_r - 1'b1;
        case (state_r)
            lioh_pkg::ST_INIT:
            begin
                if (phase_done)
                    state_nxt = lioh_pkg::ST_IDLE;
            end
            lioh_pkg::ST_IDLE:
            begin
                // Clear wins over write, write over read
                if (clr_req || wr_req)
                begin
                    state_nxt = lioh_pkg::ST_SETUP;
                    cnt_nxt   = lioh_pkg::CNT_W'(lioh_pkg::SETUP_CYC - 1);
                end
                else if (rd_req)
                begin
                    state_nxt = lioh_pkg::ST_READ;
                    cnt_nxt   = lioh_pkg::CNT_W'(lioh_pkg::ENABLE_CYC - 1);
                end
            end
            lioh_pkg::ST_SETUP:
            begin
                if (phase_done)
                begin
                    state_nxt = lioh_pkg::ST_PULSE;
                    cnt_nxt   = lioh_pkg::CNT_W'(lioh_pkg::PULSE_CYC - 1);
                end
            end
            lioh_pkg::ST_PULSE:
            begin
                if (phase_done)
                begin
                    state_nxt = lioh_pkg::ST_HOLD;
                    cnt_nxt   = lioh_pkg::CNT_W'(lioh_pkg::HOLD_CYC - 1);
                end
            end
            lioh_pkg::ST_HOLD, lioh_pkg::ST_READ:
            begin
                if (phase_done)
                    state_nxt = lioh_pkg::ST_IDLE;
            end
            default:
            begin
                state_nxt = lioh_pkg::ST_INIT;
            end
        endcase
    end

    // State and phase counter; reset starts with a clear pulse of full width
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            state_r <= lioh_pkg::ST_INIT;
            cnt_r   <= lioh_pkg::CNT_W'(lioh_pkg::PULSE_CYC - 1);
        end
        else
        begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
        end
    end

    // Remember which operation is under way
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            op_wr_r  <= 1'b0;
            op_clr_r <= 1'b0;
        end
        else if (state_r == lioh_pkg::ST_IDLE)
        begin
            op_clr_r <= clr_req;
            op_wr_r  <= wr_req && !clr_req;
        end
    end

    // Pin drive, all from flops
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            drive_r.port_reset_n       <= lioh_pkg::PIN_LO;
            drive_r.select_low_n       <= lioh_pkg::PIN_HI;
            drive_r.select_high        <= lioh_pkg::PIN_LO;
            drive_r.port_direction_pin <= lioh_pkg::PIN_LO;
            drive_r.latch_strobe       <= lioh_pkg::PIN_HI;
            drive_r.input_lines        <= lioh_pkg::DATA_ZERO;
        end
        else
        begin
            // Port clear held low during init and clear pulses
            drive_r.port_reset_n <= !((state_nxt == lioh_pkg::ST_INIT)
                || (state_nxt == lioh_pkg::ST_PULSE && op_clr_r));
            // Mode high only while writing, so the select clocks the latch
            drive_r.port_direction_pin <= (state_nxt != lioh_pkg::ST_IDLE)
                && (state_nxt != lioh_pkg::ST_INIT) && op_wr_nxt;
            // Select needs both terms; pulse for write, level for read
            if ((state_nxt == lioh_pkg::ST_PULSE && op_wr_r)
                || state_nxt == lioh_pkg::ST_READ)
            begin
                drive_r.select_low_n <= lioh_pkg::PIN_LO;
                drive_r.select_high  <= lioh_pkg::PIN_HI;
            end
            else
            begin
                drive_r.select_low_n <= lioh_pkg::PIN_HI;
                drive_r.select_high  <= lioh_pkg::PIN_LO;
            end
            // Strobe stays high so in input mode the peripheral strobe alone clocks the latch
            drive_r.latch_strobe <= lioh_pkg::PIN_HI;
            if (state_r == lioh_pkg::ST_IDLE && wr_req && !clr_req)
                drive_r.input_lines <= wr_data;
        end
    end

    // Read capture after the enable time has passed
    always_ff @(posedge clock)
    begin
        if (rst)
            rd_data_r <= lioh_pkg::DATA_ZERO;
        else if (state_r == lioh_pkg::ST_READ && phase_done)
            rd_data_r <= sense_s.output_lines;
    end

    // Status toward the host
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            busy_r <= 1'b1;
            done_r <= 1'b0;
        end
        else
        begin
            busy_r <= state_nxt != lioh_pkg::ST_IDLE;
            done_r <= phase_done && (state_r == lioh_pkg::ST_HOLD
                || state_r == lioh_pkg::ST_READ);
        end
    end

    // Recent selects, so the synchroniser's lag cannot leak a false request
    always_ff @(posedge clock)
    begin
        if (rst)
            sel_seen_r <= '0;
        else
            sel_seen_r <= {sel_seen_r[0], !drive_r.select_low_n};
    end

    // Interrupt seen only while we are not selecting the port ourselves,
    // since selecting pulls the pin low without a real request
    always_ff @(posedge clock)
    begin
        if (rst)
            irq_pending_r <= 1'b0;
        else
            irq_pending_r <= !sense_s.int_n && (state_r == lioh_pkg::ST_IDLE)
                && drive_r.select_low_n && !(|sel_seen_r);
    end

endmodule

// file: verif/lioh_ctrl_props.sv
/*
 Concurrent checks on the host controller's command walks and port pins.
 Assumes it is bound into every lioh_ctrl instance.
*/
`timescale 1ns/100ps
module lioh_ctrl_props #(
    parameter int unsigned DATA_W = lioh_pkg::DATA_W
) (
    // Clock and reset
    input wire logic                  clock,
    input wire logic                  rst,
    // Host command port
    input wire logic                  wr_req,
    input wire logic                  rd_req,
    input wire logic                  clr_req,
    input wire logic [DATA_W-1:0]     wr_data,
    input wire logic                  busy_r,
    input wire logic                  done_r,
    input wire logic [DATA_W-1:0]     rd_data_r,
    input wire logic                  irq_pending_r,
    // Port pins
    input wire lioh_pkg::lioh_drive_t drive_r,
    input wire lioh_pkg::lioh_sense_t sense
);
    logic sel;
    logic quiet;
    // Select as the port decodes it; idle with no request pending
    assign sel   = !drive_r.select_low_n && drive_r.select_high;
    assign quiet = !busy_r && !wr_req && !rd_req && !clr_req;

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    // Write: set-up in output mode, select pulse, release
    sequence wr_steps;
        (drive_r.port_direction_pin && !sel)[*3] ##1 sel[*6] ##1 !sel;
    endsequence
    // Clear: set-up, reset pulse, release
    sequence clr_steps;
        (drive_r.port_reset_n && !sel)[*3] ##1 (!drive_r.port_reset_n)[*6]
            ##1 drive_r.port_reset_n;
    endsequence

    chk_reset_state: assert property (disable iff (1'b0) rst |=> !drive_r.port_reset_n && busy_r)
        else $error("reset state wrong");
    chk_wr_walk: assert property (!busy_r && wr_req && !clr_req |=>
        drive_r.input_lines == $past(wr_data) ##0 wr_steps)
        else $error("write pin walk wrong");
    chk_wr_done: assert property (!busy_r && (wr_req || clr_req) |-> ##14 done_r)
        else $error("write or clear done late");
    chk_clr_walk: assert property (!busy_r && clr_req |=> clr_steps)
        else $error("clear pin walk wrong");
    chk_rd_walk: assert property (!busy_r && rd_req && !wr_req && !clr_req |=> sel ##9 done_r)
        else $error("read walk wrong");
    chk_strobe_high: assert property (drive_r.latch_strobe)
        else $error("strobe pin not high");
    chk_sel_pair: assert property (drive_r.select_low_n != drive_r.select_high)
        else $error("select pins disagree");
    chk_irq_raise: assert property ((quiet && !sense.int_n)[*4] |=> irq_pending_r)
        else $error("interrupt not seen");
    chk_irq_quiet: assert property ((sense.int_n)[*4] |=> !irq_pending_r)
        else $error("interrupt without request");
endmodule

bind lioh_ctrl lioh_ctrl_props #(.DATA_W(DATA_W)) u_props (
    .clock(clock), .rst(rst), .wr_req(wr_req), .rd_req(rd_req), .clr_req(clr_req),
    .wr_data(wr_data), .busy_r(busy_r), .done_r(done_r), .rd_data_r(rd_data_r),
    .irq_pending_r(irq_pending_r), .drive_r(drive_r), .sense(sense)
);

// file: verif/lioh_port_model.sv
/*
 Behavioural model of the latched 8-bit port with its request flag.
 Assumes the peripheral strobe idles high and combines with the host's.
*/
`timescale 1ns/100ps
module lioh_port_model (
    // Host pins and peripheral strobe
    input  wire lioh_pkg::lioh_drive_t drive,
    input  wire logic                  periph_stb,
    // Pins read back by the host
    output lioh_pkg::lioh_sense_t      sense
);
    logic       sel;
    logic       stb;
    logic       lclk;
    logic       flag_r;
    logic [7:0] q_r;
    // Select decode and latch clock source
    assign sel  = !drive.select_low_n && drive.select_high;
    assign stb  = drive.latch_strobe && periph_stb;
    assign lclk = drive.port_direction_pin ? sel : stb;
    // Latch follows while clocked; clock beats clear
    always_latch
        if (lclk)
            q_r <= drive.input_lines;
        else if (!drive.port_reset_n)
            q_r <= 8'h00;
    // Flag set by clear or select, reset on strobe fall
    always @(negedge stb or posedge sel or negedge drive.port_reset_n)
        if (!drive.port_reset_n || sel)
            flag_r <= 1'b1;
        else
            flag_r <= 1'b0;
    // Released lines show the inverse so stale data never passes
    always_comb
    begin
        sense.int_n        = !(!flag_r || sel);
        sense.output_lines = (drive.port_direction_pin || sel) ? q_r : ~q_r;
    end
endmodule

// file: verif/lioh_ctrl_bench.sv
/*
 Self-checking bench for the port controller with a port model behind it.
 Assumes the checker is bound in and the port model stands on the pins.
*/
`timescale 1ns/100ps
module lioh_ctrl_bench;
    logic                  clock = 1'b0;
    logic                  rst = 1'b1;
    logic                  wr_req = 1'b0;
    logic                  rd_req = 1'b0;
    logic                  clr_req = 1'b0;
    logic                  periph_stb = 1'b1;
    logic [7:0]            wr_data = 8'h00;
    logic                  busy_r;
    logic                  done_r;
    logic [7:0]            rd_data_r;
    logic                  irq_pending_r;
    lioh_pkg::lioh_drive_t drive_r;
    lioh_pkg::lioh_sense_t sense;
    logic [8:0]            exp_q[$];
    logic [8:0]            note;
    logic [31:0]           seed = 32'hF753;
    int                    n_errors = 0;
    int                    n_checks = 0;

    always #2.5 clock = ~clock;

    lioh_ctrl dut (.clock(clock), .rst(rst), .wr_req(wr_req), .rd_req(rd_req),
        .clr_req(clr_req), .wr_data(wr_data), .busy_r(busy_r), .done_r(done_r),
        .rd_data_r(rd_data_r), .irq_pending_r(irq_pending_r), .drive_r(drive_r), .sense(sense));
    lioh_port_model port (.drive(drive_r), .periph_stb(periph_stb), .sense(sense));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic chk_data(input string what, input logic [7:0] e, input logic [7:0] s);
        n_checks++;
        if (s !== e)
        begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", what, e, s);
        end
    endtask

    task automatic chk_bit(input string what, input logic e, input logic s);
        chk_data(what, {7'h00, e}, {7'h00, s});
    endtask

    task automatic results;
        $display("Checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Bounded wait for the controller to go idle
    task automatic idle;
        int n;
        n = 0;
        while (busy_r !== 1'b0 && n < 100)
        begin
            @(posedge clock);
            n++;
        end
    endtask

    // One request {rd, wr, clr}; poke fires a read while busy, which must be ignored
    task automatic cmd(input logic [2:0] k, input logic [7:0] d, input logic poke);
        idle();
        exp_q.push_back({k[2], d});
        {rd_req, wr_req, clr_req} <= k;
        wr_data <= d;
        @(posedge clock);
        {rd_req, wr_req, clr_req} <= 3'h0;
        @(posedge clock);
        rd_req <= poke;
        @(posedge clock);
        rd_req <= 1'b0;
        idle();
    endtask

    // Each completion takes the oldest note; reads also compare data
    always @(posedge clock)
        if (done_r === 1'b1)
        begin
            chk_bit("done_expected", 1'b1, exp_q.size() != 0);
            if (exp_q.size() != 0)
            begin
                note = exp_q.pop_front();
                if (note[8])
                    chk_data("read_data", note[7:0], rd_data_r);
            end
        end

    // Peripheral strobe stays low after its fall so the latch holds
    initial
    begin
        repeat (10) @(posedge clock);
        rst <= 1'b0;
        idle();
        periph_stb <= 1'b0;
        repeat (4) @(posedge clock);
        chk_bit("irq_after_strobe", 1'b1, irq_pending_r);
        cmd(3'h1, 8'h00, 1'b0);
        repeat (4) @(posedge clock);
        chk_bit("irq_after_clear", 1'b0, irq_pending_r);
        cmd(3'h4, 8'h00, 1'b0);
        for (int i = 0; i < 6; i++)
        begin
            seed = lfsr(seed);
            cmd(3'h2, seed[7:0], i == 0);
            cmd(3'h4, seed[7:0], 1'b0);
            repeat (4) @(posedge clock);
            chk_bit("irq_after_select", 1'b0, irq_pending_r);
        end
        periph_stb <= 1'b1;
        @(posedge clock);
        periph_stb <= 1'b0;
        repeat (4) @(posedge clock);
        chk_bit("irq_handshake", 1'b1, irq_pending_r);
        chk_data("notes_left", 8'h00, 8'(exp_q.size()));
        results();
    end

    // Watchdog well past the expected few hundred cycles
    initial
    begin
        repeat (5000) @(posedge clock);
        n_errors++;
        $display("Watchdog expired");
        results();
    end
endmodule
